//--- nor_flash_host.sv
/*
  host controller for an asynchronous parallel nor flash: read, word program
  (standard four-write or two-write fast form), identification entry, exit as one write of the user word at the user address,
  and hardware reset pulse. drives chip, output and write enables, reset,
  the accelerate high-voltage enable, and the three-signal data bus.
  assumes the flash pins are sampled only by this clock; data in is synchronised.
*/
// Notes on behaviour
// - host issues two-write program sequence while accelerate voltage is applied
// - host raises accelerate before fast operation, drops it after completion; this host drops it at deselect, before the flash finishes the program
// - host should program aligned 256-byte lines, each page once; this host programs words, flagging the last request's page on o_page_repeat
// - host restarts interrupted program or erase after reset; this host does not, it returns to idle after the recovery time
`timescale 1ns/1ps
`default_nettype none
`include "nor_host_consts.svh"
module nor_flash_host
  import nor_host_pkg::*;
#(
  parameter int ADDR_W = 22,
  parameter int DATA_W = 16
) (
  // clock and reset
  input wire logic i_clk_sys,
  input wire logic i_srst,
  // user request
  input wire logic i_req,
  input wire logic [3:0] i_op,
  input wire logic [ADDR_W-1:0] i_addr,
  input wire logic [DATA_W-1:0] i_wdata,
  input wire logic i_fast,
  output logic o_ready,
  output logic o_rvalid,
  output logic [DATA_W-1:0] o_rdata,
  output logic [ADDR_W-`ECC_PAGE_LSB-1:0] o_last_page,
  output logic o_page_repeat,
  // flash pins
  output logic o_chip_en_n,
  output logic o_out_en_n,
  output logic o_write_en_n,
  output logic o_reset_n,
  output logic o_accel_pin_hv,
  output logic [ADDR_W-1:0] o_addr,
  input wire logic [DATA_W-1:0] i_dq,
  output logic [DATA_W-1:0] o_dq,
  output logic o_dq_oe
);
  localparam int CNT_W = 8;
  localparam int NWR = 4;

  // ==========================================================
  // input synchroniser for the data pins
  logic [DATA_W-1:0] dq_meta_reg;
  logic [DATA_W-1:0] dq_sync_reg;
  always_ff @(posedge i_clk_sys)
  begin
    dq_meta_reg <= i_dq;
    dq_sync_reg <= dq_meta_reg;
  end

  // ==========================================================
  // write-cycle sequence lookup
  function automatic logic [ADDR_W-1:0] seq_addr(input logic [1:0] idx, input logic [1:0] nw,
                                                 input logic [ADDR_W-1:0] last);
    logic [1:0] pos;
    pos = idx + (2'd3 - nw);
    case (pos)
      2'd0: seq_addr = ADDR_W'(`UNLOCK_ADDR1);
      2'd1: seq_addr = ADDR_W'(`UNLOCK_ADDR2);
      2'd2: seq_addr = ADDR_W'(`UNLOCK_ADDR1);
      default: seq_addr = last;
    endcase
  endfunction : seq_addr

  function automatic logic [DATA_W-1:0] seq_data(input logic [1:0] idx, input logic [1:0] nw,
                                                 input logic [DATA_W-1:0] cmd,
                                                 input logic [DATA_W-1:0] last);
    logic [1:0] pos;
    pos = idx + (2'd3 - nw);
    case (pos)
      2'd0: seq_data = DATA_W'(`UNLOCK_DATA1);
      2'd1: seq_data = DATA_W'(`UNLOCK_DATA2);
      2'd2: seq_data = cmd;
      default: seq_data = last;
    endcase
  endfunction : seq_data

  // ==========================================================
  // state
  host_state_t st_reg, st_next;
  host_op_t op_reg, op_next;
  logic [1:0] idx_reg, idx_next;
  logic [1:0] nw_reg, nw_next;
  logic [ADDR_W-1:0] uaddr_reg, uaddr_next;
  logic [DATA_W-1:0] udata_reg, udata_next;
  logic [CNT_W-1:0] cnt_reg, cnt_next;
  logic ready_reg, ready_next;
  logic rvalid_reg, rvalid_next;
  logic [DATA_W-1:0] rdata_reg, rdata_next;
  logic ce_n_reg, ce_n_next;
  logic oe_n_reg, oe_n_next;
  logic we_n_reg, we_n_next;
  logic rst_n_reg, rst_n_next;
  logic hv_reg, hv_next;
  logic [ADDR_W-1:0] addr_reg, addr_next;
  logic [DATA_W-1:0] dq_reg, dq_next;
  logic dq_oe_reg, dq_oe_next;
  logic [ADDR_W-`ECC_PAGE_LSB-1:0] page_reg, page_next;
  logic repeat_reg, repeat_next;
  logic [CNT_W-1:0] tlen;
  logic tstart;

  nor_bus_if tbus ();
  assign tbus.start = tstart;

  nor_strobe_timer #(.CNT_W(CNT_W)) u_timer (
    .i_clk_sys(i_clk_sys),
    .i_srst(i_srst),
    .i_len(tlen),
    .bus(tbus)
  );

  always_comb
  begin
    st_next = st_reg;
    op_next = op_reg;
    idx_next = idx_reg;
    nw_next = nw_reg;
    uaddr_next = uaddr_reg;
    udata_next = udata_reg;
    cnt_next = cnt_reg;
    ready_next = 1'b0;
    rvalid_next = 1'b0;
    rdata_next = rdata_reg;
    ce_n_next = ce_n_reg;
    oe_n_next = oe_n_reg;
    we_n_next = we_n_reg;
    rst_n_next = rst_n_reg;
    hv_next = hv_reg;
    addr_next = addr_reg;
    dq_next = dq_reg;
    dq_oe_next = dq_oe_reg;
    page_next = page_reg;
    repeat_next = repeat_reg;
    tstart = 1'b0;
    tlen = CNT_W'(`WRITE_PULSE_CYCLES);
    case (st_reg)
      ST_RESET:
      begin
        // hold reset low for the pulse width; outputs floated by the flash
        rst_n_next = 1'b0;
        ce_n_next = 1'b1;
        oe_n_next = 1'b1;
        we_n_next = 1'b1;
        dq_oe_next = 1'b0;
        hv_next = 1'b0;
        tstart = (cnt_reg == '0);
        tlen = CNT_W'(`RESET_PULSE_CYCLES);
        cnt_next = CNT_W'(1);
        if (tbus.done)
        begin
          rst_n_next = 1'b1;
          st_next = ST_RECOVER;
          cnt_next = '0;
        end
      end
      ST_RECOVER:
      begin
        tstart = (cnt_reg == '0);
        tlen = CNT_W'(`RESET_RECOVERY_CYCLES);
        cnt_next = CNT_W'(1);
        if (tbus.done)
        begin
          st_next = ST_IDLE;
          ready_next = 1'b1;
        end
      end
      ST_IDLE:
      begin
        ready_next = 1'b1;
        // deselect between accesses so the flash idles in standby
        ce_n_next = 1'b1;
        oe_n_next = 1'b1;
        we_n_next = 1'b1;
        dq_oe_next = 1'b0;
        if (i_req)
        begin
          ready_next = 1'b0;
          op_next = host_op_t'(i_op);
          uaddr_next = i_addr;
          udata_next = i_wdata;
          idx_next = 2'd0;
          case (i_op)
            OP_READ:
            begin
              ce_n_next = 1'b0;
              oe_n_next = 1'b0;
              addr_next = i_addr;
              tstart = 1'b1;
              // the synchroniser delays the pins, so wait its depth on top of the access time
              tlen = CNT_W'(`ACCESS_CYCLES + `SYNC_STAGES);
              st_next = ST_READ;
            end
            OP_PROGRAM:
            begin
              // fast form drives the high voltage first, then two writes
              hv_next = i_fast;
              nw_next = i_fast ? 2'd1 : 2'd3;
              if (uaddr_reg[ADDR_W-1:`ECC_PAGE_LSB] == i_addr[ADDR_W-1:`ECC_PAGE_LSB])
                repeat_next = 1'b1;
              else
                repeat_next = 1'b0;
              page_next = i_addr[ADDR_W-1:`ECC_PAGE_LSB];
              st_next = ST_WR_HIGH;
              tstart = 1'b1;
            end
            OP_IDENT:
            begin
              // table from its start: both unlocks, then the command, no user word
              nw_next = 2'd3;
              st_next = ST_WR_HIGH;
              tstart = 1'b1;
            end
            OP_EXIT_IDENT:
            begin
              nw_next = 2'd0;
              st_next = ST_WR_HIGH;
              tstart = 1'b1;
            end
            OP_HW_RESET:
            begin
              st_next = ST_RESET;
              cnt_next = '0;
            end
            default:
            begin
              ready_next = 1'b1;
            end
          endcase
        end
      end
      ST_READ:
      begin
        if (tbus.done)
        begin
          rdata_next = dq_sync_reg;
          rvalid_next = 1'b1;
          oe_n_next = 1'b1;
          st_next = ST_PULSE;
          tstart = 1'b1;
          tlen = CNT_W'(2);
        end
      end
      ST_WR_HIGH:
      begin
        if (tbus.done)
        begin
          ce_n_next = 1'b0;
          we_n_next = 1'b0;
          addr_next = seq_addr(idx_reg, nw_reg, uaddr_reg);
          dq_next = seq_data(idx_reg, nw_reg,
                             (op_reg == OP_IDENT) ? DATA_W'(`CMD_IDENT) :
                             (op_reg == OP_EXIT_IDENT) ? DATA_W'(`CMD_RESET_READ) :
                             DATA_W'(`CMD_PROGRAM), udata_reg);
          dq_oe_next = 1'b1;
          tstart = 1'b1;
          st_next = ST_WR_LOW;
        end
      end
      ST_WR_LOW:
      begin
        if (tbus.done)
        begin
          we_n_next = 1'b1;
          tstart = 1'b1;
          if (idx_reg == nw_reg || (op_reg == OP_IDENT && idx_reg == 2'd2))
            st_next = ST_PULSE;
          else
          begin
            idx_next = idx_reg + 2'd1;
            st_next = ST_WR_HIGH;
          end
        end
      end
      ST_PULSE:
      begin
        if (tbus.done)
        begin
          ce_n_next = 1'b1;
          dq_oe_next = 1'b0;
          // flash finishes the program on its own after deselect
          hv_next = 1'b0;
          st_next = ST_IDLE;
          ready_next = 1'b1;
        end
      end
      default:
      begin
        st_next = ST_RESET;
        cnt_next = '0;
      end
    endcase
  end

  always_ff @(posedge i_clk_sys)
  begin
    if (i_srst)
    begin
      st_reg <= ST_RESET;
      op_reg <= OP_READ;
      idx_reg <= 2'd0;
      nw_reg <= 2'd0;
      uaddr_reg <= '1;
      udata_reg <= '0;
      cnt_reg <= '0;
      ready_reg <= 1'b0;
      rvalid_reg <= 1'b0;
      rdata_reg <= '0;
      ce_n_reg <= 1'b1;
      oe_n_reg <= 1'b1;
      we_n_reg <= 1'b1;
      rst_n_reg <= 1'b0;
      hv_reg <= 1'b0;
      addr_reg <= '0;
      dq_reg <= '0;
      dq_oe_reg <= 1'b0;
      page_reg <= '0;
      repeat_reg <= 1'b0;
    end
    else
    begin
      st_reg <= st_next;
      op_reg <= op_next;
      idx_reg <= idx_next;
      nw_reg <= nw_next;
      uaddr_reg <= uaddr_next;
      udata_reg <= udata_next;
      cnt_reg <= cnt_next;
      ready_reg <= ready_next;
      rvalid_reg <= rvalid_next;
      rdata_reg <= rdata_next;
      ce_n_reg <= ce_n_next;
      oe_n_reg <= oe_n_next;
      we_n_reg <= we_n_next;
      rst_n_reg <= rst_n_next;
      hv_reg <= hv_next;
      addr_reg <= addr_next;
      dq_reg <= dq_next;
      dq_oe_reg <= dq_oe_next;
      page_reg <= page_next;
      repeat_reg <= repeat_next;
    end
  end

  assign o_ready = ready_reg;
  assign o_rvalid = rvalid_reg;
  assign o_rdata = rdata_reg;
  assign o_last_page = page_reg;
  assign o_page_repeat = repeat_reg;
  assign o_chip_en_n = ce_n_reg;
  assign o_out_en_n = oe_n_reg;
  assign o_write_en_n = we_n_reg;
  assign o_reset_n = rst_n_reg;
  assign o_accel_pin_hv = hv_reg;
  assign o_addr = addr_reg;
  assign o_dq = dq_reg;
  assign o_dq_oe = dq_oe_reg;
endmodule : nor_flash_host
`default_nettype wire

//--- nor_host_consts.svh
/*
  timing counts and command constants for the parallel nor flash host controller.
  assumes a 100 MHz system clock; included by bare name.
*/
`ifndef NOR_HOST_CONSTS_SVH
`define NOR_HOST_CONSTS_SVH

`define CLK_PERIOD_NS 10
// address access time of the flash, ns
`define ADDRESS_ACCESS_TIME_NS 70
// address access time in whole cycles before sampling, least time rounds up
`define ACCESS_CYCLES ((`ADDRESS_ACCESS_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
// flops of the data-in synchroniser; read data reaches the sequencer this much later
`define SYNC_STAGES 2
// write strobe low and high widths, ns
`define WRITE_PULSE_NS 40
`define WRITE_PULSE_CYCLES ((`WRITE_PULSE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
// reset pulse width, ns
`define RESET_PULSE_WIDTH_NS 500
`define RESET_PULSE_CYCLES ((`RESET_PULSE_WIDTH_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
// recovery after reset release before first command, ns
`define RESET_RECOVERY_NS 200
`define RESET_RECOVERY_CYCLES ((`RESET_RECOVERY_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
// unlock and command words (16-bit mode)
`define UNLOCK_ADDR1 22'h000555
`define UNLOCK_ADDR2 22'h0002AA
`define UNLOCK_DATA1 16'h00AA
`define UNLOCK_DATA2 16'h0055
`define CMD_PROGRAM 16'h00A0
`define CMD_IDENT 16'h0090
`define CMD_RESET_READ 16'h00F0
`define IDLE_ADDR 22'h000000
// one ecc page is 32 bytes, 16 words: word address bits above the low four
`define ECC_PAGE_LSB 4
`define WRITE_BUFFER_BYTES 256

`endif

//--- nor_host_pkg.sv
/*
  types for the nor flash host controller.
  assumes nor_host_consts.svh is on the include path.
*/
package nor_host_pkg;
  typedef enum logic [3:0]
  {
    OP_READ = 4'h0,
    OP_PROGRAM = 4'h1,
    OP_IDENT = 4'h2,
    OP_EXIT_IDENT = 4'h3,
    OP_HW_RESET = 4'h4
  } host_op_t;

  typedef enum logic [6:0]
  {
    ST_RESET = 7'b0000001,
    ST_IDLE = 7'b0000010,
    ST_READ = 7'b0000100,
    ST_WR_LOW = 7'b0001000,
    ST_WR_HIGH = 7'b0010000,
    ST_PULSE = 7'b0100000,
    ST_RECOVER = 7'b1000000
  } host_state_t;
endpackage : nor_host_pkg

//--- nor_bus_if.sv
/*
  interface carrying one timed phase request (write, read, reset or recovery) between the sequencer and the strobe timer.
  assumes both ends share i_clk_sys.
*/
`timescale 1ns/1ps
`default_nettype none
interface nor_bus_if;
  logic start;
  logic done;
  modport seq (output start, input done);
  modport tmr (input start, output done);
endinterface : nor_bus_if
`default_nettype wire

//--- nor_strobe_timer.sv
/*
  cycle counter that times one strobe phase of a flash bus cycle.
  assumes start is a one-cycle pulse from the sequencer; done pulses when the count ends.
*/
`timescale 1ns/1ps
`default_nettype none
module nor_strobe_timer #(
  parameter int CNT_W = 8
) (
  // clock and reset
  input wire logic i_clk_sys,
  input wire logic i_srst,
  // phase length
  input wire logic [CNT_W-1:0] i_len,
  // request and completion
  nor_bus_if.tmr bus
);
  logic [CNT_W-1:0] cnt_reg;
  logic [CNT_W-1:0] cnt_next;
  logic busy_reg;
  logic busy_next;
  logic done_reg;
  logic done_next;

  always_comb
  begin
    cnt_next = cnt_reg;
    busy_next = busy_reg;
    done_next = 1'b0;
    if (bus.start)
    begin
      cnt_next = i_len;
      busy_next = 1'b1;
    end
    else if (busy_reg)
    begin
      if (cnt_reg <= CNT_W'(1))
      begin
        busy_next = 1'b0;
        done_next = 1'b1;
      end
      else
      begin
        cnt_next = cnt_reg - CNT_W'(1);
      end
    end
  end

  always_ff @(posedge i_clk_sys)
  begin
    if (i_srst)
    begin
      cnt_reg <= '0;
      busy_reg <= 1'b0;
      done_reg <= 1'b0;
    end
    else
    begin
      cnt_reg <= cnt_next;
      busy_reg <= busy_next;
      done_reg <= done_next;
    end
  end

  assign bus.done = done_reg;
endmodule : nor_strobe_timer
`default_nettype wire

//--- nor_flash_host_props.sv
/*
  assertions on the flash pins and handshake of nor_flash_host.
  assumes it is bound to nor_flash_host and sees only its ports.
*/
`timescale 1ns/1ps
`default_nettype none
module nor_flash_host_props #(
  parameter int ADDR_W = 22,
  parameter int DATA_W = 16
) (
  // clock and reset
  input wire logic i_clk_sys,
  input wire logic i_srst,
  // watched outputs
  input wire logic o_ready,
  input wire logic o_chip_en_n,
  input wire logic o_out_en_n,
  input wire logic o_write_en_n,
  input wire logic o_reset_n,
  input wire logic o_accel_pin_hv,
  input wire logic o_dq_oe
);
  // ==========
  // helper counters
  logic [2:0] wr_cnt_reg;
  logic [2:0] wr_cnt_next;
  logic [7:0] rst_cnt_reg;
  logic [7:0] rst_cnt_next;
  logic we_n_d_reg;
  always_comb
  begin
    wr_cnt_next = o_accel_pin_hv ? wr_cnt_reg + 3'(we_n_d_reg & ~o_write_en_n) : 3'h0;
    rst_cnt_next = o_reset_n ? 8'h00 : rst_cnt_reg + 8'(rst_cnt_reg != 8'hFF);
  end
  always_ff @(posedge i_clk_sys)
  begin
    we_n_d_reg <= i_srst | o_write_en_n;
    wr_cnt_reg <= i_srst ? 3'h0 : wr_cnt_next;
    rst_cnt_reg <= i_srst ? 8'h00 : rst_cnt_next;
  end
  // ==========
  // properties
  default clocking cb @(posedge i_clk_sys);
  endclocking
  default disable iff (i_srst);
  hv_before_write_a: assert property ($rose(o_accel_pin_hv) |-> o_write_en_n && !o_ready)
    else $error("accelerate voltage raised during a write or while idle");
  fast_two_writes_a: assert property ($fell(o_accel_pin_hv) |-> wr_cnt_reg == 3'h2)
    else $error("fast program did not use exactly two writes");
  hv_idle_low_a: assert property (o_ready |-> !o_accel_pin_hv)
    else $error("accelerate voltage left on after the operation");
  // one cycle of slack for the registered release edge
  reset_width_a: assert property ($rose(o_reset_n) |-> rst_cnt_reg >= 8'h31)
    else $error("reset pulse too short");
  reset_quiet_a: assert property (!o_reset_n |-> o_write_en_n && !o_dq_oe)
    else $error("bus activity during reset pulse");
  reset_recover_a: assert property ($rose(o_reset_n) |-> !o_ready [*8])
    else $error("ready too soon after reset pulse");
  write_form_a: assert property (!o_write_en_n |-> !o_chip_en_n && o_out_en_n && o_dq_oe)
    else $error("write cycle with wrong enables");
  read_form_a: assert property (!o_out_en_n |-> !o_dq_oe && o_write_en_n)
    else $error("host drives data while flash outputs enabled");
endmodule : nor_flash_host_props
bind nor_flash_host nor_flash_host_props #(.ADDR_W(ADDR_W), .DATA_W(DATA_W)) i_props (
  .i_clk_sys(i_clk_sys), .i_srst(i_srst), .o_ready(o_ready), .o_chip_en_n(o_chip_en_n),
  .o_out_en_n(o_out_en_n), .o_write_en_n(o_write_en_n), .o_reset_n(o_reset_n),
  .o_accel_pin_hv(o_accel_pin_hv), .o_dq_oe(o_dq_oe));
`default_nettype wire

//--- nor_flash_model.sv
/*
  behavioural model of the parallel nor flash facing nor_flash_host.
  assumes the host drives every pin; the model has no clock.
*/
`timescale 1ns/1ps
`default_nettype none
module nor_flash_model #(
  parameter logic [7:0] ID_CODE = 8'h5A // arbitrary identification value
) (
  // host-driven pins
  input wire logic i_chip_en_n,
  input wire logic i_out_en_n,
  input wire logic i_write_en_n,
  input wire logic i_reset_n,
  input wire logic i_accel_pin_hv,
  input wire logic [21:0] i_addr,
  input wire logic [15:0] i_dq,
  // data back to the host
  output logic [15:0] o_dq
);
  logic [15:0] mem [logic [21:0]];
  int page_cnt [logic [21:0]];
  logic ident = 1'b0;
  int st = 0;
  int upd = 0;
  logic [15:0] rd;
  logic [21:0] pg;
  // write protect is left open here; its pull-up holds it high
  wire logic protect_open = 1'b1;
  // ==========
  // command sequencing, sampled once the strobe edge has settled
  always @(negedge i_write_en_n)
  begin
    #1;
    if (!i_chip_en_n && i_reset_n && protect_open)
    begin
      if (st == 3)
      begin
        // stored at once, so a deselect after the strobe cannot cut the program short
        mem[i_addr] = (mem.exists(i_addr) ? mem[i_addr] : 16'hFFFF) & i_dq;
        // a count above one means ecc is off; only an erase, never issued here, clears it
        pg = i_addr >> 4;
        page_cnt[pg] = (page_cnt.exists(pg) ? page_cnt[pg] : 0) + 1;
        st = 0;
      end
      else if (i_accel_pin_hv && i_addr == 22'h000555 && i_dq == 16'h00A0) st = 3;
      else if (st == 0 && i_dq == 16'h00F0) ident = 1'b0;
      else if (st == 0) st = (i_addr == 22'h000555 && i_dq == 16'h00AA) ? 1 : 0;
      else if (st == 1) st = (i_addr == 22'h0002AA && i_dq == 16'h0055) ? 2 : 0;
      else
      begin
        ident = ident | (i_dq == 16'h0090);
        st = (i_dq == 16'h00A0) ? 3 : 0;
      end
      upd++;
    end
  end
  always @(negedge i_reset_n)
  begin
    st = 0;
    ident = 1'b0;
    upd++;
  end
  // ==========
  // read path: no pull on the bus, so a released bus shows the inverse
  always @(i_addr, i_chip_en_n, i_out_en_n, i_reset_n, i_write_en_n, upd)
  begin
    // no stored bit faults, so correction on the first page access returns the word as stored
    rd = mem.exists(i_addr) ? mem[i_addr] : 16'hFFFF;
    if (ident) rd = {8'h00, ID_CODE};
    // data stays latched while selected and stable, through sleep and its standby
    if (!i_chip_en_n && !i_out_en_n && i_reset_n && i_write_en_n) o_dq <= #70 rd;
    else o_dq <= #1 ~rd;
  end
endmodule : nor_flash_model
`default_nettype wire

//--- nor_flash_host_tb.sv
/*
  self-checking bench for nor_flash_host against the flash model.
  assumes nor_flash_model and the bound checker are compiled before it.
*/
`timescale 1ns/1ps
`default_nettype none
module nor_flash_host_tb;
  localparam logic [7:0] ID = 8'hC3; // arbitrary identification value
  logic i_clk_sys = 1'b0;
  logic i_srst, i_req, i_fast, o_ready, o_rvalid, o_page_repeat, o_dq_oe;
  logic o_chip_en_n, o_out_en_n, o_write_en_n, o_reset_n, o_accel_pin_hv;
  logic [3:0] i_op;
  logic [21:0] i_addr, o_addr, prev_a, a1;
  logic [15:0] i_wdata, o_rdata, i_dq, o_dq, d1, d2;
  logic [17:0] o_last_page;
  logic [15:0] exp_q [$];
  int miscompares, n_tests, seed;
  always #5 i_clk_sys = ~i_clk_sys;
  nor_flash_host i_dut (.i_clk_sys(i_clk_sys), .i_srst(i_srst), .i_req(i_req), .i_op(i_op),
    .i_addr(i_addr), .i_wdata(i_wdata), .i_fast(i_fast), .o_ready(o_ready),
    .o_rvalid(o_rvalid), .o_rdata(o_rdata), .o_last_page(o_last_page),
    .o_page_repeat(o_page_repeat), .o_chip_en_n(o_chip_en_n), .o_out_en_n(o_out_en_n),
    .o_write_en_n(o_write_en_n), .o_reset_n(o_reset_n), .o_accel_pin_hv(o_accel_pin_hv),
    .o_addr(o_addr), .i_dq(i_dq), .o_dq(o_dq), .o_dq_oe(o_dq_oe));
  nor_flash_model #(.ID_CODE(ID)) i_flash (.i_chip_en_n(o_chip_en_n), .i_out_en_n(o_out_en_n),
    .i_write_en_n(o_write_en_n), .i_reset_n(o_reset_n), .i_accel_pin_hv(o_accel_pin_hv),
    .i_addr(o_addr), .i_dq(o_dq), .o_dq(i_dq));
  // ==========
  // tasks
  task automatic finish_test;
    if (miscompares == 0 && n_tests > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : finish_test
  task automatic cmp_rd(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      miscompares++;
      $display("BAD %0t read %h exp %h", $time, got, exp);
    end
  endtask : cmp_rd
  task automatic cmp_page(input logic [18:0] got, input logic [18:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      miscompares++;
      $display("BAD %0t page %h exp %h", $time, got, exp);
    end
  endtask : cmp_page
  task automatic wait_ready;
    int n;
    n = 0;
    while (o_ready !== 1'b1 && n < 3000)
    begin
      @(posedge i_clk_sys);
      #1;
      n++;
    end
    if (n >= 3000) miscompares++;
  endtask : wait_ready
  // for reads d is the expected word
  task automatic do_op(input logic [3:0] op, input logic [21:0] a, input logic [15:0] d,
    input logic f);
    if (op == 4'h0) exp_q.push_back(d);
    i_op = op;
    i_addr = a;
    i_wdata = d;
    i_fast = f;
    i_req = 1'b1;
    @(posedge i_clk_sys);
    #1;
    i_req = 1'b0;
    @(posedge i_clk_sys);
    #1;
    wait_ready();
    prev_a = a;
  endtask : do_op
  task automatic prog(input logic [21:0] a, input logic [15:0] d, input logic f);
    logic rep;
    rep = (a[21:4] == prev_a[21:4]);
    do_op(4'h1, a, d, f);
    cmp_page({o_page_repeat, o_last_page}, {rep, a[21:4]});
  endtask : prog
  // ==========
  // result monitor
  always @(posedge i_clk_sys)
  begin
    if (o_rvalid === 1'b1 && exp_q.size() > 0) cmp_rd(o_rdata, exp_q.pop_front());
  end
  // ==========
  // main sequence
  initial
  begin
    seed = 83950;
    miscompares = 0;
    n_tests = 0;
    prev_a = 22'h000000;
    {i_srst, i_req, i_op, i_addr, i_wdata, i_fast} = {1'b1, 1'b0, 4'h0, 22'h0, 16'h0, 1'b0};
    a1 = 22'($random(seed));
    a1[4:0] = 5'h0A;
    d1 = 16'($random(seed));
    d2 = 16'($random(seed));
    repeat (20) @(posedge i_clk_sys);
    #1;
    i_srst = 1'b0;
    wait_ready();
    do_op(4'h0, 22'h000010, 16'hFFFF, 1'b0);
    prog(a1, d1, 1'b0);
    do_op(4'h0, a1, d1, 1'b0);
    prog(a1 + 22'h1, d2, 1'b1);
    do_op(4'h0, a1 + 22'h1, d2, 1'b0);
    do_op(4'h2, 22'h0, 16'h0, 1'b0);
    do_op(4'h0, a1, {8'h00, ID}, 1'b0);
    do_op(4'h3, 22'h0, 16'h00F0, 1'b0);
    do_op(4'hF, a1, d2, 1'b0);
    do_op(4'h0, a1, d1, 1'b0);
    do_op(4'h2, 22'h0, 16'h0, 1'b0);
    do_op(4'h4, 22'h0, 16'h0, 1'b0);
    do_op(4'h0, a1, d1, 1'b0);
    i_srst = 1'b1;
    @(posedge i_clk_sys);
    #1;
    i_srst = 1'b0;
    wait_ready();
    do_op(4'h0, a1 + 22'h1, d2, 1'b0);
    prog(a1 + 22'h40, d1 ^ d2, 1'b1);
    do_op(4'h0, a1 + 22'h40, d1 ^ d2, 1'b0);
    repeat (5) @(posedge i_clk_sys);
    cmp_rd(16'(exp_q.size()), 16'h0000);
    finish_test();
  end
  // about 550 cycles are needed; a hang is cut off well beyond that
  initial
  begin
    repeat (20000) @(posedge i_clk_sys);
    miscompares++;
    finish_test();
  end
endmodule : nor_flash_host_tb
`default_nettype wire
